// ---- prx_pkg.sv ----
// Purpose: Shared constants and types for the pulse template RAM and receive configuration block
// Assumes: 8-bit host register port, one core clock
// Notes:   Reserved bits read as zero
package prx_pkg;

  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam int          AMP_W           = 7;
  localparam int          LOS_W           = 5;
  localparam int          RAM_AW          = 6;
  localparam int          HIST_W          = 8;

  // Register offsets
  localparam logic [7:0]  OFS_ACCESS      = 8'h08;
  localparam logic [7:0]  OFS_AMPLITUDE   = 8'h09;
  localparam logic [7:0]  OFS_RXCFG       = 8'h0a;
  localparam logic [7:0]  OFS_RXEQ        = 8'h0b;

  // Field positions
  localparam int          ACC_GO_BIT      = 7;
  localparam int          ACC_DIR_BIT     = 6;
  localparam int          ACC_INTV_LSB    = 4;
  localparam int          ACC_SAMPLE_LSB  = 0;
  localparam int          AMP_LSB         = 0;
  localparam int          RX_PDN_BIT      = 4;
  localparam int          RX_POL_BIT      = 3;
  localparam int          RX_EDGE_BIT     = 2;
  localparam int          RX_MODE_LSB     = 0;
  localparam int          EQ_BIT          = 6;
  localparam int          LOS_LSB         = 0;

  // Reset values
  localparam logic [7:0]  ACCESS_RST      = 8'h00;
  localparam logic [6:0]  AMP_RST         = 7'h00;
  localparam logic [4:0]  RXCFG_RST       = 5'h00;
  localparam logic        EQ_RST          = 1'b0;
  localparam logic [4:0]  LOS_RST         = 5'h15;

  localparam logic        DIR_WRITE       = 1'b0;
  localparam logic [7:0]  RDATA_UNMAPPED  = 8'h00;

  // Zero-substitution rail patterns, index 0 newest
  localparam logic [7:0]  SUB_A_POS       = 8'h11;
  localparam logic [7:0]  SUB_A_NEG       = 8'h0a;
  localparam logic [7:0]  HDB3_CLR_MASK   = 8'hf0;

  typedef enum logic [1:0]
  {
    PRX_MODE_HDB3   = 2'h0,
    PRX_MODE_AMI    = 2'h1,
    PRX_MODE_DUAL   = 2'h2,
    PRX_MODE_SLICER = 2'h3
  } prx_mode_t;

  typedef enum logic [2:0]
  {
    ST_IDLE   = 3'b001,
    ST_ACCESS = 3'b010,
    ST_LOAD   = 3'b100
  } prx_acc_state_t;

  typedef struct packed
  {
    logic       busy;
    logic       dir;
    logic [1:0] interval_index;
    logic [3:0] sample_index;
  } prx_access_t;

  typedef struct packed
  {
    logic       power_down;
    logic       rx_data_polarity;
    logic       rx_clk_falling;
    prx_mode_t  rx_decode_mode;
  } prx_rxcfg_t;

  typedef struct packed
  {
    logic pos;
    logic neg;
  } prx_rail_t;

endpackage

// ---- prx_tmpl_ram.sv ----
// Purpose: Pulse template sample store, 4 intervals of 16 samples
// Assumes: Single port, registered read data
// Notes:   Contents are undefined until written
module prx_tmpl_ram
  import prx_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic                wr_en,
  input  wire logic                rd_en,
  input  wire logic [RAM_AW-1:0]   addr,
  input  wire logic [AMP_W-1:0]    wdata,
  output logic      [AMP_W-1:0]    rdata
);

  logic [AMP_W-1:0] mem [0:(1<<RAM_AW)-1];
  logic [AMP_W-1:0] next_rdata;

  always_comb
  begin
    next_rdata = rdata;
    if (rd_en)
    begin
      next_rdata = mem[addr];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (wr_en)
    begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rdata <= AMP_RST;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end

endmodule

// ---- prx_rx_edge.sv ----
// Purpose: Picks the receive clock edge that advances the receive data
// Assumes: Receive clock is slow against core_clk and synchronous to it
// Notes:   Strobe is one core cycle wide
module prx_rx_edge
(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic rx_clk_in,
  input  wire logic falling_sel,
  output logic      strobe
);

  logic clk_prev;
  logic next_clk_prev;

  always_comb
  begin
    next_clk_prev = rx_clk_in;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      clk_prev <= 1'b0;
    end
    else
    begin
      clk_prev <= next_clk_prev;
    end
  end

  assign strobe = falling_sel ? (clk_prev & ~rx_clk_in) : (~clk_prev & rx_clk_in);

endmodule

// ---- prx_top.sv ----
// Purpose: Template RAM indirect access and receive path configuration registers
// Assumes: Host port accesses are single-cycle strobes; line inputs synchronous to core_clk
// Notes:   Decoded data runs through an 8-bit delay so both substitution codes fit the window
//
// Operation
// - Writing one to the access trigger bit starts the chosen template RAM access.
// - The direction bit makes the access a write when zero and a read when one.
// - Bits 5-4 pick one of four unit intervals, code 00 the leftmost.
// - Bits 3-0 pick one of sixteen samples in the interval, code 0000 the leftmost.
// - An indirect write stores the seven-bit amplitude field into the addressed sample.
// - An indirect read leaves the stored amplitude in the amplitude field for the host.
// - Receive config bit 4 powers the receiver down when one.
// - Bit 3 makes the receive data outputs active low when one.
// - Bit 2 picks the falling receive clock edge when one and is ignored in slicer mode.
// - Mode 00 removes HDB3 or B8ZS substitutions and outputs single-rail NRZ.
// - Mode 01 decodes AMI and outputs single-rail NRZ.
// - Mode 10 bypasses the decoder and outputs retimed dual-rail NRZ.
// - Mode 11 bypasses recovery and decoding and outputs raw slicer RZ rails.
// - Equalizer bit 6 turns the equalizer and programmable loss levels on.
// - The loss threshold field resets to 10101, each code step lowering levels by 2 dB.
module prx_top
  import prx_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   reg_wr_en,
  input  wire logic                   reg_rd_en,
  input  wire logic [prx_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [prx_pkg::DATA_W-1:0] reg_wdata,
  output logic      [prx_pkg::DATA_W-1:0] reg_rdata,
  output logic                        reg_rd_valid,
  input  wire logic                   t1_mode,
  input  wire logic                   rx_clk_in,
  input  wire prx_pkg::prx_rail_t     rx_cdr_rails,
  input  wire prx_pkg::prx_rail_t     rx_slicer_rails,
  output logic                        rx_data_out,
  output logic                        rx_positive_rail_out,
  output logic                        rx_negative_rail_out,
  output logic                        rx_power_down,
  output logic                        equalizer_enable,
  output logic      [prx_pkg::LOS_W-1:0] signal_loss_threshold_sel
);

  import prx_pkg::*;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
    reg_hit = (a == o);
  endfunction

  prx_acc_state_t   state;
  prx_acc_state_t   next_state;
  prx_access_t      acc;
  prx_access_t      next_acc;
  logic [AMP_W-1:0] sample_amplitude;
  logic [AMP_W-1:0] next_sample_amplitude;
  prx_rxcfg_t       rxcfg;
  prx_rxcfg_t       next_rxcfg;
  logic             next_equalizer_enable;
  logic [LOS_W-1:0] next_signal_loss_threshold_sel;
  logic [DATA_W-1:0] next_reg_rdata;
  logic             next_reg_rd_valid;
  logic             ram_wr;
  logic             ram_rd;
  logic [AMP_W-1:0] ram_rdata;
  logic             wr_access;
  logic             wr_ampl;
  logic             wr_rxcfg;
  logic             wr_rxeq;

  assign wr_access = reg_wr_en & reg_hit(reg_addr, OFS_ACCESS);
  assign wr_ampl   = reg_wr_en & reg_hit(reg_addr, OFS_AMPLITUDE);
  assign wr_rxcfg  = reg_wr_en & reg_hit(reg_addr, OFS_RXCFG);
  assign wr_rxeq   = reg_wr_en & reg_hit(reg_addr, OFS_RXEQ);

  // Indirect access sequencer
  always_comb
  begin
    next_state            = state;
    next_acc              = acc;
    next_sample_amplitude = sample_amplitude;
    ram_wr                = 1'b0;
    ram_rd                = 1'b0;
    // Hardware read-back beats a host write in the same cycle
    if (wr_ampl && state != ST_LOAD)
    begin
      next_sample_amplitude = reg_wdata[AMP_LSB +: AMP_W];
    end
    case (state)
      ST_IDLE:
      begin
        // Writes while busy are dropped so the address cannot shift mid-access
        if (wr_access)
        begin
          next_acc.dir            = reg_wdata[ACC_DIR_BIT];
          next_acc.interval_index = reg_wdata[ACC_INTV_LSB +: 2];
          next_acc.sample_index   = reg_wdata[ACC_SAMPLE_LSB +: 4];
          if (reg_wdata[ACC_GO_BIT])
          begin
            next_acc.busy = 1'b1;
            next_state    = ST_ACCESS;
          end
        end
      end
      ST_ACCESS:
      begin
        if (acc.dir == DIR_WRITE)
        begin
          ram_wr        = 1'b1;
          next_acc.busy = 1'b0;
          next_state    = ST_IDLE;
        end
        else
        begin
          ram_rd     = 1'b1;
          next_state = ST_LOAD;
        end
      end
      ST_LOAD:
      begin
        next_sample_amplitude = ram_rdata;
        next_acc.busy         = 1'b0;
        next_state            = ST_IDLE;
      end
      default:
      begin
        next_acc.busy = 1'b0;
        next_state    = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state            <= ST_IDLE;
      acc              <= ACCESS_RST;
      sample_amplitude <= AMP_RST;
    end
    else
    begin
      state            <= next_state;
      acc              <= next_acc;
      sample_amplitude <= next_sample_amplitude;
    end
  end

  prx_tmpl_ram u_ram
  (
    .core_clk (core_clk),
    .rst      (rst),
    .wr_en    (ram_wr),
    .rd_en    (ram_rd),
    .addr     ({acc.interval_index, acc.sample_index}),
    .wdata    (sample_amplitude),
    .rdata    (ram_rdata)
  );

  // Receive configuration registers and host read port
  always_comb
  begin
    next_rxcfg                     = rxcfg;
    next_equalizer_enable          = equalizer_enable;
    next_signal_loss_threshold_sel = signal_loss_threshold_sel;
    next_reg_rdata                 = reg_rdata;
    next_reg_rd_valid              = reg_rd_en;
    if (wr_rxcfg)
    begin
      next_rxcfg.power_down       = reg_wdata[RX_PDN_BIT];
      next_rxcfg.rx_data_polarity = reg_wdata[RX_POL_BIT];
      next_rxcfg.rx_clk_falling   = reg_wdata[RX_EDGE_BIT];
      next_rxcfg.rx_decode_mode   = prx_mode_t'(reg_wdata[RX_MODE_LSB +: 2]);
    end
    if (wr_rxeq)
    begin
      next_equalizer_enable          = reg_wdata[EQ_BIT];
      // Reserved codes are stored as written; range is the host's duty
      next_signal_loss_threshold_sel = reg_wdata[LOS_LSB +: LOS_W];
    end
    if (reg_rd_en)
    begin
      next_reg_rdata = RDATA_UNMAPPED;
      if (reg_hit(reg_addr, OFS_ACCESS))
      begin
        next_reg_rdata = acc;
      end
      if (reg_hit(reg_addr, OFS_AMPLITUDE))
      begin
        next_reg_rdata = {1'b0, sample_amplitude};
      end
      if (reg_hit(reg_addr, OFS_RXCFG))
      begin
        next_reg_rdata = {3'h0, rxcfg};
      end
      if (reg_hit(reg_addr, OFS_RXEQ))
      begin
        next_reg_rdata = {1'b0, equalizer_enable, 1'b0, signal_loss_threshold_sel};
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rxcfg                     <= RXCFG_RST;
      equalizer_enable          <= EQ_RST;
      signal_loss_threshold_sel <= LOS_RST;
      reg_rdata                 <= RDATA_UNMAPPED;
      reg_rd_valid              <= 1'b0;
    end
    else
    begin
      rxcfg                     <= next_rxcfg;
      equalizer_enable          <= next_equalizer_enable;
      signal_loss_threshold_sel <= next_signal_loss_threshold_sel;
      reg_rdata                 <= next_reg_rdata;
      reg_rd_valid              <= next_reg_rd_valid;
    end
  end

  assign rx_power_down = rxcfg.power_down;

  // Receive decode and output path
  logic              rx_strobe;
  logic [HIST_W-1:0] hist_pos;
  logic [HIST_W-1:0] hist_neg;
  logic [HIST_W-1:0] dat;
  logic              last_pos;
  logic [HIST_W-1:0] next_hist_pos;
  logic [HIST_W-1:0] next_hist_neg;
  logic [HIST_W-1:0] next_dat;
  logic              next_last_pos;
  logic              next_rx_data_out;
  logic              next_rx_positive_rail_out;
  logic              next_rx_negative_rail_out;
  logic              pulse;
  logic              inv;

  prx_rx_edge u_edge
  (
    .core_clk    (core_clk),
    .rst         (rst),
    .rx_clk_in   (rx_clk_in),
    .falling_sel (rxcfg.rx_clk_falling),
    .strobe      (rx_strobe)
  );

  assign pulse = rx_cdr_rails.pos | rx_cdr_rails.neg;
  assign inv   = rxcfg.rx_data_polarity;

  always_comb
  begin
    next_hist_pos             = hist_pos;
    next_hist_neg             = hist_neg;
    next_dat                  = dat;
    next_last_pos             = last_pos;
    next_rx_data_out          = rx_data_out;
    next_rx_positive_rail_out = rx_positive_rail_out;
    next_rx_negative_rail_out = rx_negative_rail_out;
    if (rxcfg.power_down)
    begin
      // Idle outputs sit at the inactive level
      next_hist_pos             = '0;
      next_hist_neg             = '0;
      next_dat                  = '0;
      next_rx_data_out          = inv;
      next_rx_positive_rail_out = inv;
      next_rx_negative_rail_out = inv;
    end
    else
    begin
      case (rxcfg.rx_decode_mode)
        PRX_MODE_SLICER:
        begin
          next_rx_data_out          = inv;
          next_rx_positive_rail_out = rx_slicer_rails.pos ^ inv;
          next_rx_negative_rail_out = rx_slicer_rails.neg ^ inv;
        end
        PRX_MODE_DUAL:
        begin
          if (rx_strobe)
          begin
            next_rx_data_out          = inv;
            next_rx_positive_rail_out = rx_cdr_rails.pos ^ inv;
            next_rx_negative_rail_out = rx_cdr_rails.neg ^ inv;
          end
        end
        default:
        begin
          if (rx_strobe)
          begin
            next_hist_pos = {hist_pos[HIST_W-2:0], rx_cdr_rails.pos};
            next_hist_neg = {hist_neg[HIST_W-2:0], rx_cdr_rails.neg};
            next_dat      = {dat[HIST_W-2:0], pulse};
            if (pulse)
            begin
              next_last_pos = rx_cdr_rails.pos;
            end
            if (rxcfg.rx_decode_mode == PRX_MODE_HDB3)
            begin
              if (t1_mode)
              begin
                if ((next_hist_pos == SUB_A_POS && next_hist_neg == SUB_A_NEG) ||
                    (next_hist_pos == SUB_A_NEG && next_hist_neg == SUB_A_POS))
                begin
                  next_dat = '0;
                end
              end
              else if (pulse && (rx_cdr_rails.pos == last_pos))
              begin
                next_dat = next_dat & HDB3_CLR_MASK;
              end
            end
            next_rx_data_out          = dat[HIST_W-1] ^ inv;
            next_rx_positive_rail_out = inv;
            next_rx_negative_rail_out = inv;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      hist_pos             <= '0;
      hist_neg             <= '0;
      dat                  <= '0;
      last_pos             <= 1'b0;
      rx_data_out          <= 1'b0;
      rx_positive_rail_out <= 1'b0;
      rx_negative_rail_out <= 1'b0;
    end
    else
    begin
      hist_pos             <= next_hist_pos;
      hist_neg             <= next_hist_neg;
      dat                  <= next_dat;
      last_pos             <= next_last_pos;
      rx_data_out          <= next_rx_data_out;
      rx_positive_rail_out <= next_rx_positive_rail_out;
      rx_negative_rail_out <= next_rx_negative_rail_out;
    end
  end

endmodule

// ---- prx_checker.sv ----
// Purpose: Port assertions for prx_top
// Assumes: One clock domain, synchronous reset
// Notes:   Receive config is shadowed from host writes
module prx_checker
  import prx_pkg::*;
(
  input wire logic               core_clk,
  input wire logic               rst,
  input wire logic               reg_wr_en,
  input wire logic               reg_rd_en,
  input wire logic [7:0]         reg_addr,
  input wire logic [7:0]         reg_wdata,
  input wire logic [7:0]         reg_rdata,
  input wire logic               reg_rd_valid,
  input wire prx_pkg::prx_rail_t rx_slicer_rails,
  input wire logic               rx_data_out,
  input wire logic               rx_positive_rail_out,
  input wire logic               rx_negative_rail_out,
  input wire logic               rx_power_down,
  input wire logic               equalizer_enable,
  input wire logic [4:0]         signal_loss_threshold_sel
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [4:0] cfg;
  logic [4:0] next_cfg;
  logic [1:0] exp_rails;
  logic [1:0] next_exp;
  logic       slc_q;
  logic       next_slc;
  logic [7:0] wd_q;

  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);

  always_comb
  begin
    next_cfg = (reg_wr_en && reg_addr == OFS_RXCFG) ? reg_wdata[4:0] : cfg;
    next_exp = rx_slicer_rails ^ {2{cfg[3]}};
    next_slc = cfg[1:0] == 2'h3 && !cfg[4];
  end

  // Shadow lags the write by one edge, like the design register
  always_ff @(posedge core_clk)
  begin
    cfg <= rst ? 5'h00 : next_cfg;
    slc_q <= rst ? 1'b0 : next_slc;
    exp_rails <= next_exp;
    wd_q <= reg_wdata;
  end

  valid_align_a: assert property (reg_rd_valid == $past(reg_rd_en))
    else $error("read valid misaligned");
  unmapped_rd_a: assert property (reg_rd_en && (reg_addr < OFS_ACCESS || reg_addr > OFS_RXEQ)
    |=> reg_rdata == RDATA_UNMAPPED) else $error("unmapped read not zero");
  rdata_hold_a: assert property (!reg_rd_en |=> $stable(reg_rdata))
    else $error("read data changed without read");
  pdn_bit_a: assert property (
    reg_wr_en && reg_addr == OFS_RXCFG |=> rx_power_down == wd_q[4])
    else $error("power down bit wrong");
  eq_field_a: assert property (
    reg_wr_en && reg_addr == OFS_RXEQ |=> equalizer_enable == wd_q[6]
    && signal_loss_threshold_sel == wd_q[4:0]) else $error("equalizer register wrong");
  los_hold_a: assert property (
    !(reg_wr_en && reg_addr == OFS_RXEQ) |=> $stable(signal_loss_threshold_sel))
    else $error("threshold changed without write");
  slicer_pass_a: assert property (
    slc_q |-> {rx_positive_rail_out, rx_negative_rail_out} == exp_rails)
    else $error("slicer rails wrong");
  pdn_level_a: assert property (
    cfg[4] && !(reg_wr_en && reg_addr == OFS_RXCFG)
    |=> {rx_data_out, rx_positive_rail_out, rx_negative_rail_out} == {3{cfg[3]}})
    else $error("power down level wrong");
endmodule

// ---- prx_host.sv ----
// Purpose: Host processor model on the register port
// Assumes: Drives at falling edges
// Notes:   Released address and data show the inverse of the last value
module prx_host
  import prx_pkg::*;
(
  input  wire logic                       core_clk,
  input  wire logic [prx_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                       reg_rd_valid,
  output logic                            reg_wr_en,
  output logic                            reg_rd_en,
  output logic      [prx_pkg::ADDR_W-1:0] reg_addr,
  output logic      [prx_pkg::DATA_W-1:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic ok;

  initial
  begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    ok = 1'b1;
  end

  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    @(negedge core_clk);
    reg_wr_en = 1'b1;
    reg_addr = adr;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
    reg_addr = ~adr;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] adr, output logic [7:0] d);
    @(negedge core_clk);
    reg_rd_en = 1'b1;
    reg_addr = adr;
    @(negedge core_clk);
    reg_rd_en = 1'b0;
    reg_addr = ~adr;
    ok = ok & reg_rd_valid;
    d = reg_rdata;
  endtask

  task automatic acc(input logic dir, input logic [5:0] adr, inout logic [6:0] amp);
    logic [7:0] st;
    int         n;
    st = 8'h80;
    if (!dir)
      wr(OFS_AMPLITUDE, {1'b0, amp});
    wr(OFS_ACCESS, {1'b1, dir, adr});
    // Bounded poll, a stuck busy clears ok
    for (n = 0; n < 8 && st[7] !== 1'b0; n++)
      rd(OFS_ACCESS, st);
    ok = ok & (st === {1'b0, dir, adr});
    if (dir)
    begin
      rd(OFS_AMPLITUDE, st);
      amp = st[6:0];
    end
  endtask
endmodule

// ---- prx_top_test.sv ----
// Purpose: Self-checking bench for prx_top
// Assumes: Host model owns the register port
// Notes:   Decoded bit k is expected after receive edge k+8
module prx_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import prx_pkg::*;

  logic       core_clk;
  logic       rst;
  logic       t1_mode;
  logic       rx_clk_in;
  prx_rail_t  cdr;
  prx_rail_t  slc;
  logic       sel;
  logic       inv;
  logic       lp;
  logic       b;
  logic [1:0] last;
  logic [7:0] r;
  logic [7:0] d;
  logic [6:0] a;
  logic [6:0] mem [64];
  logic [5:0] ad [8];
  logic [1:0] q_r [$];
  logic       q_e [$];
  int         n_mismatch;
  int         samples_checked;
  int         i;
  int         k;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rd_valid;
  logic       dout;
  logic       pout;
  logic       nout;
  logic       pdn;
  logic       eq;
  logic [4:0] los;

  prx_host host
  (
    .core_clk(core_clk), .reg_rdata(rdata), .reg_rd_valid(rd_valid), .reg_wr_en(wr_en),
    .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata)
  );
  prx_top dut
  (
    .core_clk(core_clk), .rst(rst), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_rd_valid(rd_valid),
    .t1_mode(t1_mode), .rx_clk_in(rx_clk_in), .rx_cdr_rails(cdr), .rx_slicer_rails(slc),
    .rx_data_out(dout), .rx_positive_rail_out(pout), .rx_negative_rail_out(nout),
    .rx_power_down(pdn), .equalizer_enable(eq), .signal_loss_threshold_sel(los)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = !core_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Expected rails after the polarity bit
  function automatic logic [1:0] rail_exp(input logic [1:0] p, input logic v);
    rail_exp = p ^ {2{v}};
  endfunction

  task automatic put(input logic [1:0] p, input logic e);
    q_r.push_back(p);
    q_e.push_back(e);
  endtask

  // Data moves with the ignored clock edge, so a wrong edge shows mid-symbol
  task automatic sym(input logic [1:0] p, input logic mid);
    cdr = prx_rail_t'(p);
    rx_clk_in = sel;
    repeat (4) @(negedge core_clk);
    if (mid) chk({6'h0, pout, nout}, {6'h0, last});
    rx_clk_in = !sel;
    repeat (4) @(negedge core_clk);
    last = rail_exp(p, inv);
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    $display("ERROR %0t timeout", $time);
    stop_test();
  end

  initial
  begin
    rst = 1'b1;
    t1_mode = 1'b0;
    rx_clk_in = 1'b0;
    cdr = '0;
    slc = '0;
    sel = 1'b0;
    inv = 1'b0;
    n_mismatch = 0;
    samples_checked = 0;
    i = $urandom(71);
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    for (k = 0; k < 5; k++)
    begin
      host.rd(8'(8'h08 + k), r);
      chk(r, k == 3 ? 8'h15 : 8'h00);
    end
    for (k = 0; k < 6; k++)
    begin
      d = {1'b0, 1'($urandom), 1'b0, 5'(k == 0 ? 0 : k == 1 ? 10 : $urandom % 11)};
      host.wr(OFS_RXEQ, d | 8'ha0);
      host.rd(OFS_RXEQ, r);
      chk(r, d);
      chk({1'b0, eq, 1'b0, los}, d);
    end
    for (k = 0; k < 8; k++)
    begin
      ad[k] = 6'(k == 0 ? 0 : k == 1 ? 63 : $urandom);
      a = 7'($urandom);
      mem[ad[k]] = a;
      host.acc(1'b0, ad[k], a);
    end
    for (k = 0; k < 8; k++)
    begin
      host.acc(1'b1, ad[k], a);
      chk({1'b0, a}, {1'b0, mem[ad[k]]});
    end
    chk({7'h0, host.ok}, 8'h01);
    for (k = 0; k < 2; k++)
    begin
      sel = k[0];
      inv = 1'($urandom);
      host.wr(OFS_RXCFG, {4'h0, inv, sel, PRX_MODE_DUAL});
      for (i = 0; i < 12; i++)
      begin
        sym(2'($urandom), i > 0);
        chk({6'h0, pout, nout}, {6'h0, last});
      end
    end
    sel = 1'b0;
    for (k = 0; k < 3; k++)
    begin
      t1_mode = k == 1;
      inv = 1'($urandom);
      host.wr(OFS_RXCFG, {4'h0, inv, 1'b0, k == 2 ? PRX_MODE_AMI : PRX_MODE_HDB3});
      q_r.delete();
      q_e.delete();
      lp = 1'b0;
      for (i = 0; i < 16; i++)
      begin
        b = i == 0 ? 1'b1 : 1'($urandom);
        lp = lp ^ b;
        put(b ? {lp, !lp} : 2'b00, b);
      end
      // Same-polarity pulse: removed by the decoders, a mark for AMI
      put(2'b00, 1'b0);
      put(2'b00, 1'b0);
      put(2'b00, 1'b0);
      put({lp, !lp}, k == 2);
      if (k == 1)
      begin
        put({!lp, lp}, 1'b0);
        put(2'b00, 1'b0);
        put({!lp, lp}, 1'b0);
        put({lp, !lp}, 1'b0);
      end
      for (i = 0; i < 10; i++)
        put(2'b00, 1'b0);
      for (i = 0; i < q_r.size(); i++)
      begin
        sym(q_r[i], 1'b0);
        if (i >= 9) chk({7'h0, dout}, {7'h0, q_e[i - 8] ^ inv});
      end
    end
    inv = 1'($urandom);
    host.wr(OFS_RXCFG, {4'h0, inv, 1'b1, PRX_MODE_SLICER});
    for (i = 0; i < 20; i++)
    begin
      slc = prx_rail_t'(2'($urandom));
      @(negedge core_clk);
      chk({6'h0, pout, nout}, {6'h0, rail_exp(slc, inv)});
    end
    host.wr(OFS_RXCFG, 8'hf8);
    @(negedge core_clk);
    chk({4'h0, pdn, dout, pout, nout}, 8'h0f);
    host.rd(OFS_RXCFG, r);
    chk(r, 8'h18);
    stop_test();
  end
endmodule

bind prx_top prx_checker chk_i
(
  .core_clk(core_clk), .rst(rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rd_valid(reg_rd_valid), .rx_slicer_rails(rx_slicer_rails), .rx_data_out(rx_data_out),
  .rx_positive_rail_out(rx_positive_rail_out), .rx_negative_rail_out(rx_negative_rail_out),
  .rx_power_down(rx_power_down), .equalizer_enable(equalizer_enable),
  .signal_loss_threshold_sel(signal_loss_threshold_sel)
);
